// ===== rtl/bitband_pkg.sv
// bitband_pkg: address map, attribute codes and request carriers for the bit-band remapper
// assumes a 32-bit address space with word-aligned alias accesses
`default_nettype none
package bitband_pkg;
    // ---------------------------------------------------------------
    // address map
    // ---------------------------------------------------------------
    localparam logic [31:0] SRAM_BAND_BASE  = 32'h2000_0000; // sram bit-band region
    localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000; // sram alias window
    localparam logic [31:0] PERI_BAND_BASE  = 32'h4000_0000; // peripheral bit-band region
    localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000; // peripheral alias window
    localparam logic [31:0] EXT_SHR_BASE    = 32'hA000_0000; // shareable external device
    localparam logic [31:0] EXT_NSH_BASE    = 32'hC000_0000; // non-shareable external device
    localparam logic [31:0] PPB_BASE        = 32'hE000_0000; // private peripheral bus
    localparam logic [31:0] VENDOR_BASE     = 32'hE010_0000; // vendor-specific device
    localparam logic [31:0] PERI_REGION_END = 32'h6000_0000; // end of peripheral region
    localparam int          BAND_BITS       = 20;            // 1MB band
    localparam int          ALIAS_BITS      = 25;            // 32MB alias
    localparam int          BYTE_LSB        = 5;             // byte offset times 32
    localparam int          BIT_LSB         = 2;             // bit number times 4
    localparam logic [31:0] ONE_WORD        = 32'h0000_0001; // alias read of a set bit
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000; // alias read of a clear bit

    // ---------------------------------------------------------------
    // attribute codes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MEM_NORMAL   = 2'h0,
        MEM_DEVICE   = 2'h1,
        MEM_STRONGLY = 2'h2
    } mem_type_t;

    typedef enum logic [1:0] {
        BAR_NONE = 2'h0,
        BAR_DATA = 2'h1, // data_memory_barrier
        BAR_SYNC = 2'h2, // data_sync_barrier
        BAR_INST = 2'h3  // instruction_sync_barrier
    } barrier_t;

    // core request
    typedef struct packed {
        logic        fetch; // instruction fetch
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
    } core_req_t;

    // downstream request with attributes
    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        lock;      // held across a read-modify-write
        logic        shareable;
        mem_type_t   mtype;
    } mem_req_t;
endpackage : bitband_pkg
`default_nettype wire

// ===== rtl/bit_band_alias_remapper.sv
// bit_band_alias_remapper: alias decode, read-modify-write, attributes and barrier ordering
// assumes one outstanding downstream transfer; downstream answers with a one-cycle i_mem_rvalid
//
// Summary of operation
// - direct sram band accesses pass unchanged
// - sram alias data remapped, fetches pass
// - peripheral alias data remapped, fetches refused
// - direct peripheral band accesses pass unchanged
// - alias write is read, modify, write
// - alias offset is byte*32 plus bit*4
// - 1MB band regions, 32MB alias windows
// - bit number selects byte bit 0-7
// - written bit0 sets or clears target
// - written bits 31:1 are ignored
// - alias read returns zero or one
// - peripheral and vendor space unconstrained
// - data barrier drains before next transfer
// - sync barrier drains before next instruction
// - instruction barrier drains and requests refetch
// - strongly-ordered accesses issued strictly in order
`default_nettype none
module bit_band_alias_remapper
    import bitband_pkg::*;
(
    input  wire logic      i_clk,          // system clock
    input  wire logic      i_rst_n,        // async reset, active low
    input  wire logic      i_ce,           // clock enable, freezes all state
    input  wire logic      i_req_valid,    // core request present
    input  wire core_req_t i_req,          // core request
    input  wire barrier_t  i_barrier,      // barrier with the request slot
    input  wire logic      i_mem_ready,    // downstream accepts request
    input  wire logic      i_mem_rvalid,   // downstream response pulse
    input  wire logic [31:0] i_mem_rdata,  // downstream read data
    output logic           o_req_ready,    // request taken in the previous cycle
    output logic           o_rsp_valid,    // response pulse to core
    output logic [31:0]    o_rsp_rdata,    // response data to core
    output logic           o_rsp_fault,    // fetch refused
    output logic           o_exec_hold,    // stall later instructions
    output logic           o_refetch,      // flush and refetch pulse
    output logic           o_mem_valid,    // downstream request valid
    output mem_req_t       o_mem_req       // downstream request
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001, // take requests
        ST_ISSUE = 6'b000010, // downstream request pending
        ST_WAIT  = 6'b000100, // waiting for response
        ST_RMW_W = 6'b001000, // write-back pending
        ST_RMW_A = 6'b010000, // waiting write-back ack
        ST_DRAIN = 6'b100000  // barrier completion
    } state_t;

    // one-hot states cost a few flops but each decodes from a single bit
    state_t      state_r, state_nxt;
    logic        alias_r;     // current access is via alias
    logic [2:0]  bit_r;       // target bit in byte
    logic [1:0]  lane_r;      // byte lane of target byte
    logic        wbit_r;      // value to store
    logic        wr_r;        // core asked a write
    logic        inst_r;      // barrier was instruction sync
    logic        sync_r;      // barrier holds execution
    logic [31:0] rmw_data_r;  // modified word for write-back

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // alias window hit, 32MB
    function automatic logic in_alias(input logic [31:0] a, input logic [31:0] base);
        in_alias = (a[31:ALIAS_BITS] == base[31:ALIAS_BITS]);
    endfunction : in_alias

    // alias word to band byte: offset/32 is byte, bits 4:2 the bit
    function automatic logic [31:0] band_addr(input logic [31:0] a, input logic [31:0] band);
        band_addr = band | {12'h000, a[BYTE_LSB +: BAND_BITS]};
    endfunction : band_addr

    // attributes by region; an alias lies in the same region as its band,
    // so the core address gives the right attributes for remapped accesses
    // limitation: the default map is fixed, no programmable region table
    function automatic mem_type_t region_type(input logic [31:0] a);
        if (a >= VENDOR_BASE) begin
            region_type = MEM_DEVICE;
        end else if (a >= PPB_BASE) begin
            region_type = MEM_STRONGLY;
        end else if (a >= EXT_SHR_BASE) begin
            region_type = MEM_DEVICE;
        end else if (a >= PERI_BAND_BASE && a < PERI_REGION_END) begin
            region_type = MEM_DEVICE;
        end else begin
            region_type = MEM_NORMAL;
        end
    endfunction : region_type

    // shareability; peripheral and vendor space carry no extra constraint
    function automatic logic region_share(input logic [31:0] a);
        if (a >= VENDOR_BASE) begin
            region_share = 1'b0;
        end else if (a >= PPB_BASE) begin
            region_share = 1'b1;
        end else if (a >= EXT_NSH_BASE) begin
            region_share = 1'b0;
        end else if (a >= EXT_SHR_BASE) begin
            region_share = 1'b1;
        end else begin
            region_share = 1'b0;
        end
    endfunction : region_share

    // ---------------------------------------------------------------
    // request classification
    // ---------------------------------------------------------------
    logic hit_sram_alias; // sram window
    logic hit_peri_alias; // peripheral window
    logic do_alias;       // remap this access
    logic refuse;         // fetch to peripheral alias
    logic take;           // request taken in idle
    // fetches never alias: a fetch to the sram window goes out unchanged

    always_comb begin
        hit_sram_alias = in_alias(i_req.addr, SRAM_ALIAS_BASE);
        hit_peri_alias = in_alias(i_req.addr, PERI_ALIAS_BASE);
        do_alias = !i_req.fetch && (hit_sram_alias || hit_peri_alias);
        refuse   = i_req.fetch && hit_peri_alias;
        take     = (state_r == ST_IDLE) && i_req_valid;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    // one transfer at a time keeps every region, strongly-ordered included, in order
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    if (i_barrier != BAR_NONE) begin
                        state_nxt = ST_DRAIN;
                    end else if (!refuse) begin
                        state_nxt = ST_ISSUE;
                    end
                end
            end
            ST_ISSUE: begin
                if (i_mem_ready) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (i_mem_rvalid) begin
                    // alias write continues with write-back
                    state_nxt = (alias_r && wr_r) ? ST_RMW_W : ST_IDLE;
                end
            end
            ST_RMW_W: begin
                if (i_mem_ready) begin
                    state_nxt = ST_RMW_A;
                end
            end
            ST_RMW_A: begin
                if (i_mem_rvalid) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DRAIN: begin
                state_nxt = ST_IDLE; // nothing left outstanding by construction
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;
        end else if (i_ce) begin
            state_r <= state_nxt;
        end
    end

    // ---------------------------------------------------------------
    // captured request
    // ---------------------------------------------------------------
    // kept here because the core may drop its request once it is taken
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            alias_r <= 1'b0;
            bit_r   <= 3'h0;
            lane_r  <= 2'h0;
            wbit_r  <= 1'b0;
            wr_r    <= 1'b0;
            inst_r  <= 1'b0;
            sync_r  <= 1'b0;
        end else if (i_ce && take) begin
            alias_r <= do_alias;
            bit_r   <= i_req.addr[BIT_LSB +: 3];
            lane_r  <= i_req.addr[BYTE_LSB +: 2];
            wbit_r  <= i_req.wdata[0];
            wr_r    <= i_req.write;
            inst_r  <= (i_barrier == BAR_INST);
            sync_r  <= (i_barrier == BAR_SYNC) || (i_barrier == BAR_INST);
        end
    end

    // ---------------------------------------------------------------
    // downstream request
    // ---------------------------------------------------------------
    // the band address for alias, otherwise the core address as is
    // lock rises with the read and falls only on the write-back answer,
    // so no other master reaches the band word in between
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_valid <= 1'b0;
            o_mem_req   <= '0;
        end else if (i_ce) begin
            if (take && i_barrier == BAR_NONE && !refuse) begin
                o_mem_valid         <= 1'b1;
                o_mem_req.write     <= i_req.write && !do_alias; // alias write reads first
                o_mem_req.wdata     <= i_req.wdata;
                o_mem_req.wstrb     <= i_req.wstrb;
                o_mem_req.lock      <= do_alias && i_req.write;
                if (do_alias) begin
                    o_mem_req.addr <= band_addr(i_req.addr,
                        hit_sram_alias ? SRAM_BAND_BASE : PERI_BAND_BASE);
                end else begin
                    o_mem_req.addr <= i_req.addr;
                end
                o_mem_req.mtype     <= region_type(i_req.addr);
                o_mem_req.shareable <= region_share(i_req.addr);
            end else if (state_r == ST_WAIT && i_mem_rvalid && alias_r && wr_r) begin
                o_mem_valid     <= 1'b1;              // write-back, lock still held
                o_mem_req.write <= 1'b1;
                o_mem_req.wdata <= rmw_data_r;
                o_mem_req.wstrb <= 4'h1 << lane_r;
            end else if ((state_r == ST_ISSUE || state_r == ST_RMW_W) && i_mem_ready) begin
                o_mem_valid <= 1'b0;
            end else if (state_r == ST_RMW_A && i_mem_rvalid) begin
                o_mem_req.lock <= 1'b0;
            end
        end
    end

    // modified word: only the target bit changes
    // the one-byte strobe limits the write-back to the target byte
    always_comb begin
        rmw_data_r = i_mem_rdata;
        rmw_data_r[{lane_r, bit_r}] = wbit_r;
    end

    // ---------------------------------------------------------------
    // core response
    // ---------------------------------------------------------------
    // every response is a one-cycle pulse; the core must catch it then
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= ZERO_WORD;
            o_rsp_fault <= 1'b0;
            o_req_ready <= 1'b0;
        end else if (i_ce) begin
            o_req_ready <= take;
            o_rsp_valid <= 1'b0;
            o_rsp_fault <= 1'b0;
            if (take && i_barrier == BAR_NONE && refuse) begin
                o_rsp_valid <= 1'b1;
                o_rsp_fault <= 1'b1;
                o_rsp_rdata <= ZERO_WORD;
            end else if (state_r == ST_WAIT && i_mem_rvalid && !(alias_r && wr_r)) begin
                o_rsp_valid <= 1'b1;
                if (alias_r) begin
                    o_rsp_rdata <= i_mem_rdata[{lane_r, bit_r}] ? ONE_WORD : ZERO_WORD;
                end else begin
                    o_rsp_rdata <= i_mem_rdata;
                end
            end else if (state_r == ST_RMW_A && i_mem_rvalid) begin
                o_rsp_valid <= 1'b1;     // alias write done after write-back
                o_rsp_rdata <= ZERO_WORD;
            end
        end
    end

    // ---------------------------------------------------------------
    // barrier effects
    // ---------------------------------------------------------------
    // hold and refetch pulse together in the cycle after the drain cycle
    // only one transfer is ever in flight, so idle means drained
    // and a single drain cycle is enough for every barrier kind
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_exec_hold <= 1'b0;
            o_refetch   <= 1'b0;
        end else if (i_ce) begin
            o_refetch <= (state_r == ST_DRAIN) && inst_r;
            o_exec_hold <= (state_r == ST_DRAIN) && sync_r;
        end
    end
endmodule : bit_band_alias_remapper
`default_nettype wire

// ===== sim/bit_band_alias_remapper_asserts.sv
// checker for the bit-band remapper, bound to its ports
// assumes the core keeps i_req and i_barrier until its next request
`default_nettype none
module bit_band_alias_remapper_asserts
    import bitband_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire core_req_t   i_req,
    input wire barrier_t    i_barrier,
    input wire logic        i_mem_ready,
    input wire logic        i_mem_rvalid,
    input wire logic [31:0] i_mem_rdata,
    input wire logic        o_req_ready,
    input wire logic        o_rsp_valid,
    input wire logic [31:0] o_rsp_rdata,
    input wire logic        o_rsp_fault,
    input wire logic        o_exec_hold,
    input wire logic        o_refetch,
    input wire logic        o_mem_valid,
    input wire mem_req_t    o_mem_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !i_ce);
    logic [4:0] bpos;   // word bit picked by the alias address
    logic       rd_bit; // that bit of the downstream answer
    logic       al_s;   // sram alias window
    logic       al_p;   // peripheral alias window
    logic       take_d; // data slot just taken
    assign bpos   = i_req.addr[6:2];
    assign rd_bit = i_mem_rdata[bpos];
    assign al_s   = i_req.addr[31:25] == 7'h11;
    assign al_p   = i_req.addr[31:25] == 7'h21;
    assign take_d = o_req_ready && i_barrier == BAR_NONE && !i_req.fetch;
    // locked read accepted, then its locked one-byte write-back
    sequence rmw_rd; o_mem_valid && i_mem_ready && o_mem_req.lock && !o_mem_req.write; endsequence
    sequence rmw_wr; o_mem_valid && o_mem_req.write && o_mem_req.lock && $onehot(o_mem_req.wstrb); endsequence

    sram_remap_a: assert property (take_d && al_s |-> o_mem_valid && !o_mem_req.write
        && o_mem_req.lock == i_req.write && o_mem_req.addr == {SRAM_BAND_BASE[31:20], i_req.addr[24:5]})
        else $error("sram alias not remapped");
    peri_remap_a: assert property (take_d && al_p |-> o_mem_valid && !o_mem_req.write
        && o_mem_req.lock == i_req.write && o_mem_req.addr == {PERI_BAND_BASE[31:20], i_req.addr[24:5]})
        else $error("peripheral alias not remapped");
    direct_pass_a: assert property (take_d && (i_req.addr[31:20] == 12'h200 || i_req.addr[31:20] == 12'h400)
        |-> o_mem_valid && o_mem_req.addr == i_req.addr && o_mem_req.write == i_req.write)
        else $error("direct band access altered");
    fetch_refuse_a: assert property (o_req_ready && i_req.fetch && al_p && i_barrier == BAR_NONE
        |-> o_rsp_valid && o_rsp_fault && !o_mem_valid ##1 !o_mem_valid)
        else $error("peripheral alias fetch not refused");
    rmw_lock_a: assert property (rmw_rd |-> o_mem_req.lock throughout (##[1:40] rmw_wr))
        else $error("locked write-back missing");
    bit_write_a: assert property (rmw_wr |-> o_mem_req.wdata[bpos] == i_req.wdata[0]
        && o_mem_req.wstrb[i_req.addr[6:5]]) else $error("alias write bit wrong");
    alias_read_a: assert property (o_rsp_valid && !o_rsp_fault && (al_s || al_p) && !i_req.fetch
        && !i_req.write |-> o_rsp_rdata == {31'h0, $past(rd_bit)}) else $error("alias read value wrong");
    rsp_time_a: assert property (i_mem_rvalid && !o_mem_req.lock |=> o_rsp_valid)
        else $error("response not one cycle after answer");
    mem_hold_a: assert property (o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_req))
        else $error("request dropped before ready");
    attr_map_a: assert property (o_mem_valid |-> o_mem_req.shareable == (o_mem_req.addr[31:29] == 3'h5
        || o_mem_req.addr[31:20] == 12'hE00) && (o_mem_req.mtype == MEM_STRONGLY) == (o_mem_req.addr[31:20] == 12'hE00))
        else $error("region attributes wrong");
    inst_bar_a: assert property (o_req_ready && i_barrier == BAR_INST |=> o_refetch && o_exec_hold)
        else $error("refetch missing");
    sync_bar_a: assert property (o_req_ready && i_barrier == BAR_SYNC |=> o_exec_hold && !o_refetch)
        else $error("execution hold missing");
    data_bar_a: assert property (o_req_ready && i_barrier == BAR_DATA |-> !o_mem_valid ##1 !o_exec_hold)
        else $error("data barrier misbehaves");
endmodule : bit_band_alias_remapper_asserts
bind bit_band_alias_remapper bit_band_alias_remapper_asserts u_chk (.i_clk, .i_rst_n, .i_ce, .i_req, .i_barrier,
    .i_mem_ready, .i_mem_rvalid, .i_mem_rdata, .o_req_ready, .o_rsp_valid, .o_rsp_rdata, .o_rsp_fault,
    .o_exec_hold, .o_refetch, .o_mem_valid, .o_mem_req);
`default_nettype wire

// ===== sim/bit_band_mem_model.sv
// downstream memory model: one transfer at a time, prompt or slow
// assumes requests held until ready; low half sram band, high half peripheral
`default_nettype none
module bit_band_mem_model
    import bitband_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_slow,
    input  wire logic        i_mem_valid,
    input  wire mem_req_t    i_mem_req,
    output logic             o_mem_ready,
    output logic             o_mem_rvalid,
    output logic [31:0]      o_mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:255]; // backing words
    logic [31:0] rd;          // word read at acceptance
    int          wait_n;      // cycles to the answer
    initial for (int i = 0; i < 256; i++) mem[i] = $urandom;
    // accept, answer later; data line scrambles between answers
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_ready  <= 1'b0;
            o_mem_rvalid <= 1'b0;
            o_mem_rdata  <= 32'h0;
            wait_n       <= 0;
        end else begin
            o_mem_rvalid <= 1'b0;
            o_mem_rdata  <= ~o_mem_rdata;
            if (wait_n > 1) wait_n <= wait_n - 1;
            else if (wait_n == 1) begin
                wait_n       <= 0;
                o_mem_rvalid <= 1'b1;
                o_mem_rdata  <= rd;
            end else if (i_mem_valid && o_mem_ready) begin
                rd <= mem[{i_mem_req.addr[30], i_mem_req.addr[8:2]}];
                for (int b = 0; b < 4; b++)
                    if (i_mem_req.write && i_mem_req.wstrb[b])
                        mem[{i_mem_req.addr[30], i_mem_req.addr[8:2]}][8*b+:8] <= i_mem_req.wdata[8*b+:8];
                o_mem_ready <= 1'b0;
                wait_n      <= i_slow ? 1 + $urandom % 4 : 1;
            end else o_mem_ready <= !i_slow || $urandom % 2;
        end
    end
endmodule : bit_band_mem_model
`default_nettype wire

// ===== sim/test_bit_band_alias_remapper.sv
// self-checking bench for the bit-band remapper
// assumes the memory model sits on the downstream side
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module test_bit_band_alias_remapper
    import bitband_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk, i_rst_n, i_req_valid, slow, mem_ready, mem_rvalid;
    core_req_t   i_req;
    barrier_t    i_barrier;
    logic        o_req_ready, o_rsp_valid, o_rsp_fault, o_exec_hold, o_refetch, o_mem_valid;
    logic [31:0] mem_rdata, o_rsp_rdata, rdat, a, d, pre, exp_w;
    mem_req_t    o_mem_req, cap;
    logic        got, rsp_seen, hold_seen, ref_seen, flt, w;
    int          failures, tests_run, cycles;
    logic [31:0] amap [9] = '{32'h0000_0100, 32'h2000_0040, 32'h200F_FFFC, 32'h4000_0010, 32'h6000_0000,
                              32'hA000_0000, 32'hC000_0000, 32'hE000_ED00, 32'hE010_0000};

    bit_band_alias_remapper DUT (.i_clk, .i_rst_n, .i_ce(1'b1), .i_req_valid, .i_req, .i_barrier,
        .i_mem_ready(mem_ready), .i_mem_rvalid(mem_rvalid), .i_mem_rdata(mem_rdata), .o_req_ready,
        .o_rsp_valid, .o_rsp_rdata, .o_rsp_fault, .o_exec_hold, .o_refetch, .o_mem_valid, .o_mem_req);
    bit_band_mem_model u_mem (.i_clk, .i_rst_n, .i_slow(slow), .i_mem_valid(o_mem_valid), .i_mem_req(o_mem_req),
        .o_mem_ready(mem_ready), .o_mem_rvalid(mem_rvalid), .o_mem_rdata(mem_rdata));

    // -------------------------------------------------------------
    // expectations
    // -------------------------------------------------------------
    function automatic logic [7:0] widx(input logic [31:0] x);
        return {x[30], x[8:2]};
    endfunction : widx
    function automatic logic [31:0] band(input logic [31:0] x);
        return (x[30] ? PERI_BAND_BASE : SRAM_BAND_BASE) | {12'h000, x[24:5]};
    endfunction : band
    // {shareable, type} of a region
    function automatic logic [2:0] attr(input logic [31:0] x);
        if (x[31:20] == 12'hE00) return {1'b1, MEM_STRONGLY};
        if (x[31:29] == 3'h5) return {1'b1, MEM_DEVICE};
        if (x[31:29] == 3'h2 || x >= 32'hC000_0000) return {1'b0, MEM_DEVICE};
        return {1'b0, MEM_NORMAL};
    endfunction : attr
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // one core slot; request dropped once taken, outputs sampled mid-cycle
    task automatic op(input logic f, input logic wr, input logic [31:0] x, input logic [31:0] v, input barrier_t b);
        int n;
        @(negedge i_clk);
        i_req_valid = 1'b1;
        i_req       = '{fetch: f, write: wr, addr: x, wdata: v, wstrb: 4'hF};
        i_barrier   = b;
        {got, rsp_seen, hold_seen, ref_seen, flt} = '0;
        for (n = 0; n < ((b == BAR_NONE) ? 60 : 6) && !rsp_seen; n++) begin
            @(negedge i_clk);
            if (o_req_ready === 1'b1) i_req_valid = 1'b0;
            if (o_mem_valid === 1'b1 && !got) begin got = 1'b1; cap = o_mem_req; end
            if (o_exec_hold === 1'b1) hold_seen = 1'b1;
            if (o_refetch === 1'b1) ref_seen = 1'b1;
            if (o_rsp_valid === 1'b1) begin rsp_seen = 1'b1; rdat = o_rsp_rdata; flt = o_rsp_fault; end
        end
        if (b == BAR_NONE && !rsp_seen) `CHK(rsp_seen, 1'b1)
    endtask : op

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin failures++; end_of_test(); end
    end
    initial begin
        {i_rst_n, i_req_valid, slow} = '0;
        i_req = '0;
        i_barrier = BAR_NONE;
        {failures, tests_run, cycles} = '0;
        void'($urandom(32'hA0E5));
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        foreach (amap[k]) begin
            op(0, 0, amap[k], 0, BAR_NONE);
            `CHK(cap.addr, amap[k])
            `CHK({cap.shareable, cap.mtype}, attr(amap[k]))
            `CHK(rdat, u_mem.mem[widx(amap[k])])
        end
        $display("region test done");
        for (int k = 0; k < 8; k++) begin
            a = (k[0] ? PERI_BAND_BASE : SRAM_BAND_BASE) | ($urandom & 32'h000F_FFFC);
            d = $urandom;
            op(0, 1, a, d, BAR_NONE);
            `CHK(u_mem.mem[widx(a)], d)
        end
        $display("direct write test done");
        for (int k = 0; k < 40; k++) begin
            slow = k[1];
            w = (k < 4) || k[2];
            a = (k[0] ? PERI_ALIAS_BASE : SRAM_ALIAS_BASE) | ($urandom & 32'h01FF_FFFC);
            if (k < 2) a[24:2] = '1;
            d = (k < 4) ? (k[1] ? 32'hFF : 32'h0E) : $urandom;
            pre = u_mem.mem[widx(band(a))];
            op(0, w, a, d, BAR_NONE);
            `CHK(cap.addr, band(a))
            exp_w = pre;
            exp_w[a[6:2]] = d[0];
            if (w) `CHK(u_mem.mem[widx(band(a))], exp_w)
            else `CHK(rdat, {31'h0, pre[a[6:2]]})
        end
        $display("alias test done");
        op(1, 0, SRAM_ALIAS_BASE | 32'h40, 0, BAR_NONE);
        `CHK(cap.addr, SRAM_ALIAS_BASE | 32'h40)
        op(1, 0, PERI_ALIAS_BASE | 32'h40, 0, BAR_NONE);
        `CHK({got, flt}, 2'b01)
        $display("fetch test done");
        for (int k = 1; k < 4; k++) begin
            op(0, 0, 0, 0, barrier_t'(k));
            `CHK({got, hold_seen, ref_seen}, {1'b0, k > 1, k == 3})
        end
        $display("barrier test done");
        end_of_test();
    end
endmodule : test_bit_band_alias_remapper
`default_nettype wire
